/* src/qwemc_array.v */
`timescale 1ns/10ps
// storage array: one 64-bit quadword plus 8 check bits per 72-bit location
module qwemc_array #(
    parameter W  = 72,
    parameter AW = 19
) (
    input  wire          i_clk_sys,
    input  wire          i_arst_n,
    input  wire          i_we,
    input  wire [AW-1:0] i_addr,
    input  wire [W-1:0]  i_wdata,
    output reg  [W-1:0]  o_rdata
);
    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
    end

    // read data always registered, so the controller sees it one cycle later
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= {W{1'b0}};
        end else begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule // qwemc_array

/* src/qwemc_consts.vh */
`ifndef QWEMC_CONSTS_VH
`define QWEMC_CONSTS_VH

// transfer tags on the request bus
`define QWEMC_TAG_CMD      3'h3
`define QWEMC_TAG_WDATA    3'h5

// command word layout
`define QWEMC_FUNC_HI      31
`define QWEMC_FUNC_LO      28
`define QWEMC_IO_BIT       27
`define QWEMC_ADDR_HI      26
`define QWEMC_ADDR_LO      0

// operation codes
`define QWEMC_FN_RD_MSK    4'h1
`define QWEMC_FN_WR_MSK    4'h2
`define QWEMC_FN_ILK_RD    4'h4
`define QWEMC_FN_ILK_WR    4'h7
`define QWEMC_FN_EXT_RD    4'h8
`define QWEMC_FN_EXT_WR    4'hB

// read data status codes
`define QWEMC_RS_OK        4'h0
`define QWEMC_RS_CORR      4'h1
`define QWEMC_RS_UNCORR    4'h2

// geometry
`define QWEMC_DATA_W       64
`define QWEMC_CHK_W        8
`define QWEMC_WORD_W       72
`define QWEMC_FILE_DEPTH   4
`define QWEMC_MAX_BOARDS   16
`define QWEMC_SHIFT_SMALL  13
`define QWEMC_SHIFT_BIG    15

// refresh spacing in clock cycles
`define QWEMC_REFRESH_CYC  256

`endif

/* src/qwemc_ctrl.v */
`timescale 1ns/10ps
`include "qwemc_consts.vh"
// Contract
// - six operation types are supported
// - masked write changes only selected bytes
// - masked read returns full longword
// - extended read returns two longwords
// - extended write: each quadword byte selectable
// - interlocked ops also drive lock flag
// - longword and quadword random access
// - correct single, detect double bit errors
// - every access fetches whole quadword
// - location holds 64 data, 8 check
// - command file queues four transfers
// - array bus carries quadword plus check
// - one to sixteen boards, 8K/32K each
// - refresh counter sequences array refresh
// - everything synchronous to one clock
// - read status 0000, 0001, 0010
module qwemc_ctrl #(
    parameter NUM_BOARDS  = 16,
    parameter AW          = 19,
    parameter REFRESH_CYC = `QWEMC_REFRESH_CYC
) (
    input  wire        i_clk_sys,
    input  wire        i_arst_n,
    input  wire        i_chip_big,
    input  wire        i_req_valid,
    input  wire [2:0]  i_req_tag,
    input  wire [4:0]  i_req_id,
    input  wire [3:0]  i_req_mask,
    input  wire [31:0] i_req_data,
    output reg         o_req_ready,
    output reg         o_rd_valid,
    output reg  [4:0]  o_rd_id,
    output reg  [3:0]  o_rd_status,
    output reg  [31:0] o_rd_data,
    input  wire        i_rd_ready,
    output reg         o_interlock,
    output reg         o_err_corr,
    output reg         o_err_uncorr,
    output reg  [AW-1:0] o_refresh_row
);
    localparam S_IDLE  = 3'h0;
    localparam S_DATA1 = 3'h1;
    localparam S_DATA2 = 3'h2;
    localparam S_RD    = 3'h3;
    localparam S_CHK   = 3'h4;
    localparam S_RESP2 = 3'h5;
    localparam FW      = 44;

    // hamming over positions 1..71 skipping powers of two, bit 7 is overall parity
    function [7:0] ecc_gen;
        input [63:0] d;
        integer pos, p, k;
        reg [7:0] c;
        begin
            c = 8'h00;
            k = 0;
            for (pos = 1; pos < 72; pos = pos + 1) begin
                if ((pos & (pos - 1)) != 0) begin
                    for (p = 0; p < 7; p = p + 1) begin
                        if (pos[p]) c[p] = c[p] ^ d[k];
                    end
                    k = k + 1;
                end
            end
            c[7] = ^{d, c[6:0]};
            ecc_gen = c;
        end
    endfunction

    function [63:0] ecc_fix;
        input [63:0] d;
        input [6:0]  syn;
        integer pos, k;
        reg [63:0] r;
        begin
            r = d;
            k = 0;
            for (pos = 1; pos < 72; pos = pos + 1) begin
                if ((pos & (pos - 1)) != 0) begin
                    if (pos[6:0] == syn) r[k] = ~r[k];
                    k = k + 1;
                end
            end
            ecc_fix = r;
        end
    endfunction

    function [31:0] byte_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  m;
        integer b;
        begin
            for (b = 0; b < 4; b = b + 1) begin
                byte_merge[b*8 +: 8] = m[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
            end
        end
    endfunction

    // command file: four-deep queue of bus transfers
    reg [FW-1:0] file_mem [0:`QWEMC_FILE_DEPTH-1];
    reg [1:0]    file_wp;
    reg [1:0]    file_rp;
    reg [2:0]    file_cnt;
    wire         file_push = i_req_valid && o_req_ready;
    reg          file_pop;
    wire [FW-1:0] file_head = file_mem[file_rp];
    wire [2:0]   head_tag  = file_head[43:41];
    wire [4:0]   head_id   = file_head[40:36];
    wire [3:0]   head_mask = file_head[35:32];
    wire [31:0]  head_data = file_head[31:0];
    wire         file_ne   = (file_cnt != 3'h0);
    wire [2:0]   next_file_cnt = file_cnt + {2'b00, file_push} - {2'b00, file_pop};

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            file_wp     <= 2'h0;
            file_rp     <= 2'h0;
            file_cnt    <= 3'h0;
            o_req_ready <= 1'b0;
        end else begin
            if (file_push) begin
                file_wp <= file_wp + 2'h1;
            end
            if (file_pop) begin
                file_rp <= file_rp + 2'h1;
            end
            file_cnt    <= next_file_cnt;
            o_req_ready <= (next_file_cnt != `QWEMC_FILE_DEPTH);
        end
    end

    always @(posedge i_clk_sys) begin
        if (file_push) begin
            file_mem[file_wp] <= {i_req_tag, i_req_id, i_req_mask, i_req_data};
        end
    end

    // operation state
    reg [2:0]    state;
    reg [3:0]    op_fn;
    reg [4:0]    op_id;
    reg [3:0]    op_mask;
    reg [26:0]   op_addr;
    reg          op_ref;
    reg [31:0]   wd0;
    reg [31:0]   wd1;
    reg [3:0]    wm0;
    reg [3:0]    wm1;
    reg [15:0]   ref_cnt;
    reg          ref_due;

    wire [`QWEMC_WORD_W-1:0] ar_rdata;
    wire [63:0]  rd_data = ar_rdata[63:0];
    wire [7:0]   rd_chk  = ar_rdata[71:64];
    wire [7:0]   gen_chk = ecc_gen(rd_data);
    wire [6:0]   syn     = gen_chk[6:0] ^ rd_chk[6:0];
    wire         ovr     = ^ar_rdata;
    wire         err_one = ovr;
    wire         err_two = !ovr && (syn != 7'h00);
    wire [63:0]  fix_data = err_one ? ecc_fix(rd_data, syn) : rd_data;
    wire [3:0]   rd_stat = err_two ? `QWEMC_RS_UNCORR :
                           err_one ? `QWEMC_RS_CORR : `QWEMC_RS_OK;

    wire is_wr   = (op_fn == `QWEMC_FN_WR_MSK) || (op_fn == `QWEMC_FN_ILK_WR) ||
                   (op_fn == `QWEMC_FN_EXT_WR);
    wire is_ext  = (op_fn == `QWEMC_FN_EXT_RD) || (op_fn == `QWEMC_FN_EXT_WR);

    // decode of the head command
    wire [3:0]  hd_fn   = head_data[`QWEMC_FUNC_HI:`QWEMC_FUNC_LO];
    wire [26:0] hd_addr = head_data[`QWEMC_ADDR_HI:`QWEMC_ADDR_LO];
    wire [25:0] hd_quad = hd_addr[26:1];
    wire [25:0] hd_board = i_chip_big ? (hd_quad >> `QWEMC_SHIFT_BIG)
                                      : (hd_quad >> `QWEMC_SHIFT_SMALL);
    wire hd_fn_ok = (hd_fn == `QWEMC_FN_RD_MSK) || (hd_fn == `QWEMC_FN_WR_MSK) ||
                    (hd_fn == `QWEMC_FN_ILK_RD) || (hd_fn == `QWEMC_FN_ILK_WR) ||
                    (hd_fn == `QWEMC_FN_EXT_RD) || (hd_fn == `QWEMC_FN_EXT_WR);
    wire hd_in_range = (hd_board < NUM_BOARDS);
    wire hd_mine = (head_tag == `QWEMC_TAG_CMD) && !head_data[`QWEMC_IO_BIT] &&
                   hd_fn_ok && hd_in_range;
    wire hd_wr   = (hd_fn == `QWEMC_FN_WR_MSK) || (hd_fn == `QWEMC_FN_ILK_WR) ||
                   (hd_fn == `QWEMC_FN_EXT_WR);

    // merged quadword for writes and scrub write-back
    reg  [63:0] merged;
    always @* begin
        merged = fix_data;
        if (op_ref) begin // scrub must not pick up stale write bytes
            merged = fix_data;
        end else if (op_fn == `QWEMC_FN_EXT_WR) begin
            merged[31:0]  = byte_merge(fix_data[31:0], wd0, wm0);
            merged[63:32] = byte_merge(fix_data[63:32], wd1, wm1);
        end else if (op_addr[0]) begin
            merged[63:32] = byte_merge(fix_data[63:32], wd0, wm0);
        end else begin
            merged[31:0]  = byte_merge(fix_data[31:0], wd0, wm0);
        end
    end

    // response buffer: two entries so a stalled receiver drops nothing
    reg         buf_full;
    reg         b1_valid;
    reg  [4:0]  b1_id;
    reg  [3:0]  b1_status;
    reg  [31:0] b1_data;
    reg         rsp_push;
    reg  [31:0] rsp_data;
    wire        rsp_pop = o_rd_valid && i_rd_ready;
    wire        chk_ok  = (state == S_CHK) && (op_ref || is_wr || !buf_full);

    always @* begin
        rsp_push = 1'b0;
        rsp_data = fix_data[31:0];
        if (state == S_CHK && !op_ref && !is_wr && !buf_full) begin
            rsp_push = 1'b1;
            rsp_data = (op_addr[0] && !is_ext) ? fix_data[63:32] : fix_data[31:0];
        end else if (state == S_RESP2 && !buf_full) begin
            rsp_push = 1'b1;
            rsp_data = fix_data[63:32];
        end
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_valid  <= 1'b0;
            o_rd_id     <= 5'h00;
            o_rd_status <= 4'h0;
            o_rd_data   <= 32'h00000000;
            b1_valid    <= 1'b0;
            b1_id       <= 5'h00;
            b1_status   <= 4'h0;
            b1_data     <= 32'h00000000;
            buf_full    <= 1'b0;
        end else begin
            if (rsp_pop && b1_valid) begin
                o_rd_id     <= b1_id;
                o_rd_status <= b1_status;
                o_rd_data   <= b1_data;
            end else if (rsp_push && (!o_rd_valid || rsp_pop)) begin
                o_rd_id     <= op_id;
                o_rd_status <= rd_stat;
                o_rd_data   <= rsp_data;
            end
            if (rsp_push && o_rd_valid && !(rsp_pop && !b1_valid)) begin
                b1_id     <= op_id;
                b1_status <= rd_stat;
                b1_data   <= rsp_data;
            end
            o_rd_valid <= (o_rd_valid && !rsp_pop) || b1_valid || rsp_push;
            b1_valid   <= o_rd_valid && (b1_valid ? !rsp_pop : (rsp_push && !rsp_pop));
            buf_full   <= o_rd_valid && (b1_valid ? !rsp_pop : (rsp_push && !rsp_pop));
        end
    end

    // refresh spacing and the ref_due request flag
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ref_cnt <= 16'h0000;
            ref_due <= 1'b0;
        end else if (state == S_IDLE && ref_due) begin
            ref_due <= 1'b0;
        end else if (ref_cnt == REFRESH_CYC[15:0] - 16'h0001) begin
            ref_cnt <= 16'h0000;
            ref_due <= 1'b1;
        end else begin
            ref_cnt <= ref_cnt + 16'h0001;
        end
    end

    // sequencer
    always @* begin
        file_pop = 1'b0;
        if (state == S_IDLE && !ref_due && file_ne) file_pop = 1'b1;
        if ((state == S_DATA1 || state == S_DATA2) && file_ne &&
            head_tag == `QWEMC_TAG_WDATA) file_pop = 1'b1;
    end

    wire [AW-1:0] ar_addr = op_ref ? o_refresh_row : op_addr[AW:1];
    wire          ar_we   = chk_ok && (is_wr && !op_ref || op_ref && err_one);
    wire [7:0]    wr_chk  = ecc_gen(merged);

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state         <= S_IDLE;
            op_fn         <= 4'h0;
            op_id         <= 5'h00;
            op_mask       <= 4'h0;
            op_addr       <= 27'h0000000;
            op_ref        <= 1'b0;
            wd0           <= 32'h00000000;
            wd1           <= 32'h00000000;
            wm0           <= 4'h0;
            wm1           <= 4'h0;
            o_interlock   <= 1'b0;
            o_err_corr    <= 1'b0;
            o_err_uncorr  <= 1'b0;
            o_refresh_row <= {AW{1'b0}};
        end else begin
            o_err_corr   <= chk_ok && err_one;
            o_err_uncorr <= chk_ok && err_two;
            case (state)
                S_IDLE: begin
                    op_ref <= 1'b0;
                    if (ref_due) begin
                        op_ref <= 1'b1;
                        state  <= S_RD;
                    end else if (file_ne && hd_mine) begin
                        op_fn   <= hd_fn;
                        op_id   <= head_id;
                        op_mask <= head_mask;
                        op_addr <= hd_addr;
                        state   <= hd_wr ? S_DATA1 : S_RD;
                    end
                end
                S_DATA1: begin
                    if (file_ne) begin
                        wd0 <= head_data;
                        wm0 <= head_mask;
                        if (head_tag != `QWEMC_TAG_WDATA) state <= S_IDLE;
                        else state <= is_ext ? S_DATA2 : S_RD;
                    end
                end
                S_DATA2: begin
                    if (file_ne) begin
                        wd1   <= head_data;
                        wm1   <= head_mask;
                        state <= (head_tag != `QWEMC_TAG_WDATA) ? S_IDLE : S_RD;
                    end
                end
                S_RD: begin
                    state <= S_CHK;
                end
                S_CHK: begin
                    if (chk_ok) begin
                        if (op_ref) o_refresh_row <= o_refresh_row + {{(AW-1){1'b0}}, 1'b1};
                        if (op_fn == `QWEMC_FN_ILK_RD && !op_ref) o_interlock <= 1'b1;
                        if (op_fn == `QWEMC_FN_ILK_WR && !op_ref) o_interlock <= 1'b0;
                        state <= (!op_ref && op_fn == `QWEMC_FN_EXT_RD) ? S_RESP2 : S_IDLE;
                    end
                end
                S_RESP2: begin
                    if (!buf_full) state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // array holds data and check bits side by side, written as one word
    qwemc_array #(
        .W  (`QWEMC_WORD_W),
        .AW (AW)
    ) u_array (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_we      (ar_we),
        .i_addr    (ar_addr),
        .i_wdata   ({wr_chk, merged}),
        .o_rdata   (ar_rdata)
    );
endmodule // qwemc_ctrl

/* test/qwemc_ctrl_properties.sv */
`timescale 1ns/10ps
module qwemc_chk #(
    parameter AW          = 19,
    parameter REFRESH_CYC = 256
) (
    input wire          i_clk_sys,
    input wire          i_arst_n,
    input wire          i_chip_big,
    input wire          i_req_valid,
    input wire [2:0]    i_req_tag,
    input wire [4:0]    i_req_id,
    input wire [3:0]    i_req_mask,
    input wire [31:0]   i_req_data,
    input wire          o_req_ready,
    input wire          o_rd_valid,
    input wire [4:0]    o_rd_id,
    input wire [3:0]    o_rd_status,
    input wire [31:0]   o_rd_data,
    input wire          i_rd_ready,
    input wire          o_interlock,
    input wire          o_err_corr,
    input wire          o_err_uncorr,
    input wire [AW-1:0] o_refresh_row
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // words owed to requesters; a word with nothing owed is spurious
    wire       take = i_req_valid && o_req_ready && i_req_tag == 3'h3 && !i_req_data[27];
    wire [3:0] fn   = i_req_data[31:28];
    wire [7:0] add  = !take ? 8'h00 : (fn == 4'h8) ? 8'h02 :
                      (fn == 4'h1 || fn == 4'h4) ? 8'h01 : 8'h00;
    reg  [7:0]  owed;
    reg  [15:0] gap;
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            owed <= 8'h00;
            gap  <= 16'h0000;
        end else begin
            owed <= owed + add - {7'h00, o_rd_valid && i_rd_ready};
            gap  <= $changed(o_refresh_row) ? 16'h0000 : gap + 16'h0001;
        end
    end
    property p_rd_hold;
        o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable({o_rd_id, o_rd_status, o_rd_data});
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read word moved while stalled");
    property p_status_legal;
        o_rd_valid |-> o_rd_status inside {4'h0, 4'h1, 4'h2};
    endproperty
    a_status_legal: assert property (p_status_legal) else $error("bad read status");
    property p_err_excl;
        !(o_err_corr && o_err_uncorr);
    endproperty
    a_err_excl: assert property (p_err_excl) else $error("both error pulses");
    property p_ready_after_rst;
        $rose(i_arst_n) |=> o_req_ready;
    endproperty
    a_ready_after_rst: assert property (p_ready_after_rst) else $error("file not open");
    property p_refresh_step;
        $changed(o_refresh_row) |-> o_refresh_row == $past(o_refresh_row) + 1'b1;
    endproperty
    a_refresh_step: assert property (p_refresh_step) else $error("refresh row jump");
    property p_refresh_spacing;
        $changed(o_refresh_row) |=> $stable(o_refresh_row) [*8];
    endproperty
    a_refresh_spacing: assert property (p_refresh_spacing) else $error("refresh too close");
    property p_refresh_gap;
        gap < 4 * REFRESH_CYC;
    endproperty
    a_refresh_gap: assert property (p_refresh_gap) else $error("refresh stalled");
    property p_no_spurious_rd;
        o_rd_valid |-> owed != 8'h00;
    endproperty
    a_no_spurious_rd: assert property (p_no_spurious_rd) else $error("unasked read word");
    c_rd_stall: cover property (o_rd_valid && !i_rd_ready);
    c_file_full: cover property (i_req_valid && !o_req_ready);
    c_lock: cover property ($rose(o_interlock));
endmodule // qwemc_chk

bind qwemc_ctrl qwemc_chk #(.AW(AW), .REFRESH_CYC(REFRESH_CYC)) u_chk (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_chip_big(i_chip_big),
    .i_req_valid(i_req_valid), .i_req_tag(i_req_tag), .i_req_id(i_req_id),
    .i_req_mask(i_req_mask), .i_req_data(i_req_data), .o_req_ready(o_req_ready),
    .o_rd_valid(o_rd_valid), .o_rd_id(o_rd_id), .o_rd_status(o_rd_status),
    .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .o_interlock(o_interlock),
    .o_err_corr(o_err_corr), .o_err_uncorr(o_err_uncorr), .o_refresh_row(o_refresh_row));

/* test/qwemc_node.sv */
`timescale 1ns/10ps
module qwemc_node (
    input  wire        i_clk_sys,
    input  wire        i_stall,
    input  wire        i_ready,
    input  wire        i_rd_valid,
    input  wire [4:0]  i_rd_id,
    input  wire [3:0]  i_rd_status,
    input  wire [31:0] i_rd_data,
    output reg         o_valid,
    output reg  [2:0]  o_tag,
    output reg  [4:0]  o_id,
    output reg  [3:0]  o_mask,
    output reg  [31:0] o_data,
    output reg         o_rd_ready
);
    logic [40:0] rxq[$];
    integer      refused;
    initial begin
        refused = 0;
        o_rd_ready = 1'b1;
        idle_bus;
    end
    // idle bus reads as all zeros
    task idle_bus;
        begin
            o_valid = 1'b0;
            o_tag = 3'h0;
            o_id = 5'h00;
            o_mask = 4'h0;
            o_data = 32'h00000000;
        end
    endtask
    task idle;
        begin
            @(negedge i_clk_sys);
            idle_bus;
        end
    endtask
    // ready is settled at the falling edge and cannot change before the rising one
    task send(input [2:0] tag, input [4:0] id, input [3:0] mask, input [31:0] data);
        begin
            @(negedge i_clk_sys);
            o_valid = 1'b1;
            o_tag = tag;
            o_id = id;
            o_mask = mask;
            o_data = data;
            while (!i_ready) begin
                refused = refused + 1;
                @(negedge i_clk_sys);
            end
            @(posedge i_clk_sys);
        end
    endtask
    task read(input [3:0] fn, input [4:0] id, input [26:0] a);
        begin
            send(3'h3, id, 4'h0, {fn, 1'b0, a});
            idle;
        end
    endtask
    task write(input [3:0] fn, input [4:0] id, input [26:0] a,
               input [3:0] m0, input [31:0] d0, input [3:0] m1, input [31:0] d1);
        begin
            send(3'h3, id, 4'h0, {fn, 1'b0, a});
            send(3'h5, id, m0, d0);
            if (fn == 4'hB)
                send(3'h5, id, m1, d1);
            idle;
        end
    endtask
    always @(negedge i_clk_sys) o_rd_ready <= !i_stall;
    always @(posedge i_clk_sys) if (i_rd_valid && o_rd_ready)
        rxq.push_back({i_rd_id, i_rd_status, i_rd_data});
endmodule // qwemc_node

/* test/test_quadword_ecc_memory_controller.sv */
`timescale 1ns/10ps
`include "qwemc_consts.vh"
module test_quadword_ecc_memory_controller;
    localparam AW = 8;
    localparam RCYC = 64;
    reg          i_clk_sys;
    reg          i_arst_n;
    reg          stall, big;
    wire         i_req_valid, o_req_ready, o_rd_valid, i_rd_ready;
    wire         o_interlock, o_err_corr, o_err_uncorr;
    wire [2:0]   i_req_tag;
    wire [4:0]   i_req_id, o_rd_id;
    wire [3:0]   i_req_mask, o_rd_status;
    wire [31:0]  i_req_data, o_rd_data;
    wire [AW-1:0] o_refresh_row;
    integer      error_cnt, n_checks, i;
    reg  [AW-1:0] r0;
    reg  [3:0]   n_corr, n_unc;
    always @(posedge i_clk_sys) begin
        n_corr <= n_corr + {3'h0, o_err_corr};
        n_unc  <= n_unc + {3'h0, o_err_uncorr};
    end
    qwemc_node NODE (.i_clk_sys(i_clk_sys), .i_stall(stall), .i_ready(o_req_ready),
        .i_rd_valid(o_rd_valid), .i_rd_id(o_rd_id), .i_rd_status(o_rd_status),
        .i_rd_data(o_rd_data), .o_valid(i_req_valid), .o_tag(i_req_tag), .o_id(i_req_id),
        .o_mask(i_req_mask), .o_data(i_req_data), .o_rd_ready(i_rd_ready));
    qwemc_ctrl #(.NUM_BOARDS(16), .AW(AW), .REFRESH_CYC(RCYC)) DUT (.i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n), .i_chip_big(big), .i_req_valid(i_req_valid),
        .i_req_tag(i_req_tag), .i_req_id(i_req_id), .i_req_mask(i_req_mask),
        .i_req_data(i_req_data), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
        .o_rd_id(o_rd_id), .o_rd_status(o_rd_status), .o_rd_data(o_rd_data),
        .i_rd_ready(i_rd_ready), .o_interlock(o_interlock), .o_err_corr(o_err_corr),
        .o_err_uncorr(o_err_uncorr), .o_refresh_row(o_refresh_row));
    task chk_val(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // waits bounded for the next returned word, then compares id, status and data
    task chk_rd(input [4:0] id, input [3:0] st, input [31:0] d);
        integer k;
        reg [40:0] w;
        begin
            k = 0;
            w = 41'bx;
            while (NODE.rxq.size() == 0 && k < 300) begin
                @(posedge i_clk_sys);
                k = k + 1;
            end
            if (NODE.rxq.size() != 0)
                w = NODE.rxq.pop_front();
            n_checks = n_checks + 1;
            if (w !== {id, st, d}) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH rd_word exp %h got %h", {id, st, d}, w);
            end
        end
    endtask
    task t_basic;
        begin
            NODE.write(`QWEMC_FN_EXT_WR, 5'h01, 27'h0, 4'hF, 32'h11223344, 4'hF, 32'h55667788);
            NODE.write(`QWEMC_FN_EXT_WR, 5'h01, 27'h2, 4'hF, 32'h01020304, 4'hF, 32'h05060708);
            NODE.read(`QWEMC_FN_RD_MSK, 5'h02, 27'h0);
            chk_rd(5'h02, `QWEMC_RS_OK, 32'h11223344);
            NODE.read(`QWEMC_FN_RD_MSK, 5'h03, 27'h1);
            chk_rd(5'h03, `QWEMC_RS_OK, 32'h55667788);
        end
    endtask
    task t_partial;
        begin
            NODE.write(`QWEMC_FN_WR_MSK, 5'h04, 27'h1, 4'h6, 32'hAABBCCDD, 4'h0, 32'h0);
            NODE.write(`QWEMC_FN_EXT_WR, 5'h05, 27'h2, 4'h1, 32'h000000EE, 4'h8, 32'hFF000000);
            NODE.read(`QWEMC_FN_RD_MSK, 5'h06, 27'h1);
            chk_rd(5'h06, `QWEMC_RS_OK, 32'h55BBCC88);
            NODE.read(`QWEMC_FN_RD_MSK, 5'h07, 27'h0);
            chk_rd(5'h07, `QWEMC_RS_OK, 32'h11223344);
            NODE.read(`QWEMC_FN_EXT_RD, 5'h08, 27'h3);
            chk_rd(5'h08, `QWEMC_RS_OK, 32'h010203EE);
            chk_rd(5'h08, `QWEMC_RS_OK, 32'hFF060708);
        end
    endtask
    task t_lock;
        begin
            NODE.read(`QWEMC_FN_ILK_RD, 5'h09, 27'h0);
            chk_rd(5'h09, `QWEMC_RS_OK, 32'h11223344);
            chk_val("interlock_set", 32'h1, {31'h0, o_interlock});
            NODE.write(`QWEMC_FN_ILK_WR, 5'h0A, 27'h0, 4'hC, 32'h99990000, 4'h0, 32'h0);
            NODE.read(`QWEMC_FN_RD_MSK, 5'h0B, 27'h0);
            chk_rd(5'h0B, `QWEMC_RS_OK, 32'h99993344);
            chk_val("interlock_clr", 32'h0, {31'h0, o_interlock});
        end
    endtask
    // receiver stalls long enough for the read buffer and command file to fill
    task t_fill;
        begin
            NODE.refused = 0;
            stall = 1'b1;
            fork
                begin
                    for (i = 0; i < 8; i = i + 1)
                        NODE.send(3'h3, i[4:0] + 5'h10, 4'h0, {`QWEMC_FN_RD_MSK, 1'b0, 27'h0});
                    NODE.idle;
                end
                begin
                    repeat (40) @(negedge i_clk_sys);
                    stall = 1'b0;
                end
            join
            chk_val("file_refused", 32'h1, {31'h0, NODE.refused > 0});
            for (i = 0; i < 8; i = i + 1)
                chk_rd(i[4:0] + 5'h10, `QWEMC_RS_OK, 32'h99993344);
        end
    endtask
    // dropped commands return nothing, so the next word belongs to the good read
    task t_drop;
        begin
            NODE.send(3'h3, 5'h1A, 4'h0, {`QWEMC_FN_RD_MSK, 1'b1, 27'h0});
            NODE.send(3'h3, 5'h1B, 4'h0, {4'h3, 1'b0, 27'h0});
            NODE.write(`QWEMC_FN_EXT_WR, 5'h1D, 27'h40000, 4'hF, 32'h0, 4'hF, 32'h0);
            NODE.read(`QWEMC_FN_RD_MSK, 5'h1C, 27'h1);
            chk_rd(5'h1C, `QWEMC_RS_OK, 32'h55BBCC88);
            @(negedge i_clk_sys);
            big = 1'b1;
            NODE.write(`QWEMC_FN_EXT_WR, 5'h1D, 27'h40000, 4'hF, 32'h0, 4'hF, 32'h0);
            NODE.read(`QWEMC_FN_RD_MSK, 5'h1D, 27'h1);
            chk_rd(5'h1D, `QWEMC_RS_OK, 32'h0);
        end
    endtask
    task t_refresh;
        begin
            @(negedge i_clk_sys);
            r0 = o_refresh_row;
            repeat (3 * RCYC + 8) @(negedge i_clk_sys);
            r0 = o_refresh_row - r0;
            chk_val("refresh_steps", 32'h1, {31'h0, r0 == 3 || r0 == 4});
        end
    endtask
    task t_ecc;
        begin
            DUT.u_array.mem[248] = 72'h1;
            NODE.read(`QWEMC_FN_RD_MSK, 5'h1E, 27'h1F0);
            chk_rd(5'h1E, `QWEMC_RS_CORR, 32'h0);
            DUT.u_array.mem[248] = 72'h3;
            NODE.read(`QWEMC_FN_RD_MSK, 5'h1F, 27'h1F0);
            chk_rd(5'h1F, `QWEMC_RS_UNCORR, 32'h3);
            chk_val("err_pulses", 32'h11, {24'h0, n_corr, n_unc});
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        error_cnt = error_cnt + 1;
        stop_test;
    end
    initial begin
        error_cnt = 0;
        n_checks = 0;
        stall = 1'b0;
        big = 1'b0;
        {n_corr, n_unc} = 8'h00;
        // all-zero words are valid codewords, so fetches of unwritten rows stay clean
        for (i = 0; i < 256; i = i + 1)
            DUT.u_array.mem[i] = 72'h0;
        i_arst_n = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        i_arst_n = 1'b1;
        repeat (2) @(posedge i_clk_sys);
        t_basic;
        t_partial;
        t_lock;
        t_fill;
        t_drop;
        t_ecc;
        t_refresh;
        stop_test;
    end
endmodule // test_quadword_ecc_memory_controller
